// ==== verilog/sxs_exec.sv ====
`timescale 1ns/100ps
// Behaviour
// - sleep clears the watchdog count and its prescaler to zero.
// - sleep clears the active-low power-down flag and sets the active-low expiry flag.
// - subtract from file gives file minus accumulator, dest 0 to acc, 1 to file.
// - subtract from literal gives literal minus accumulator, always into the acc.
// - subtract with borrow gives file minus acc minus inverted carry, to dest.
// - nibble exchange swaps the two halves of the file value into the destination.
// - load direction copies acc to port a, b or c direction for operand 5, 6, 7, flags kept.
// - xor literal puts acc xor literal into the acc and changes only the zero flag.
// - xor file puts acc xor file into the destination chosen by the dest bit.
module sxs_exec
  import sxs_pkg::*;
#(
  parameter int WDT_WIDTH = WDT_W
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  arst_n_in,
  input  wire logic                  instr_cycle_en_in,
  input  wire sxs_pkg::sxs_instr_s   instr_in,
  input  wire logic                  wdt_enable_in,
  output logic [7:0]                 acc_out,
  output sxs_pkg::sxs_status_s       status_out,
  output sxs_pkg::sxs_file_wr_s      file_wr_out,
  output logic [7:0]                 port_a_direction_out,
  output logic [7:0]                 port_b_direction_out,
  output logic [7:0]                 port_c_direction_out,
  output logic [WDT_WIDTH-1:0]       watchdog_count_out,
  output logic [7:0]                 watchdog_prescale_out,
  output logic                       sleeping_out
);
  import sxs_pkg::*;

  // ------------------------------------------------------------
  // arithmetic and operand decode helpers
  // ------------------------------------------------------------
  // a - b - borrow; bit 8 is carry (no borrow), bit 9 the nibble carry
  function automatic logic [9:0] sub_op(input logic [7:0] a, input logic [7:0] b,
                                        input logic borrow);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, ~b} + {8'h00, ~borrow};
    low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ~borrow};
    sub_op = {low[4], full};
  endfunction

  // load direction operand: one-hot c, b, a; any other operand selects none
  function automatic logic [2:0] dir_select(input logic [6:0] operand);
    dir_select = {operand == 7'(DIR_PORT_C), operand == 7'(DIR_PORT_B),
                  operand == 7'(DIR_PORT_A)};
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0]           acc_q, acc_d;
  sxs_status_s          status_q, status_d;
  sxs_file_wr_s         wr_q, wr_d;
  logic [7:0]           dir_a_q, dir_a_d, dir_b_q, dir_b_d, dir_c_q, dir_c_d;
  logic [WDT_WIDTH-1:0] wdt_q, wdt_d;
  logic [7:0]           pre_q, pre_d;
  logic                 sleep_q, sleep_d;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic       go;
  logic       sleep_go;
  logic [2:0] dir_sel;

  assign go       = instr_cycle_en_in & instr_in.valid;
  assign sleep_go = go && (instr_in.op == SXS_OP_SLEEP);
  assign dir_sel  = dir_select(instr_in.file_addr);

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  // ticks on the instruction clock; sleep wins over a tick in the same cycle
  always_comb begin
    wdt_d = wdt_q;
    pre_d = pre_q;
    if (instr_cycle_en_in && wdt_enable_in) begin
      pre_d = pre_q + 8'h01;
      if (pre_q == PRE_TERM) begin
        wdt_d = wdt_q + {{(WDT_WIDTH-1){1'b0}}, 1'b1};
      end
    end
    if (sleep_go) begin
      wdt_d = WDT_WIDTH'(WDT_RST);
      pre_d = PRE_RST;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wdt_q <= WDT_WIDTH'(WDT_RST);
      pre_q <= PRE_RST;
    end else begin
      wdt_q <= wdt_d;
      pre_q <= pre_d;
    end
  end

  // ------------------------------------------------------------
  // execution
  // ------------------------------------------------------------
  always_comb begin
    logic [9:0] sr;
    logic [7:0] res;
    sr       = 10'h000;
    res      = 8'h00;
    acc_d    = acc_q;
    status_d = status_q;
    wr_d     = '{we: 1'b0, addr: instr_in.file_addr, data: 8'h00};
    dir_a_d  = dir_a_q;
    dir_b_d  = dir_b_q;
    dir_c_d  = dir_c_q;
    sleep_d  = sleep_q;
    if (go) begin
      unique case (instr_in.op)
        SXS_OP_SLEEP: begin
          status_d.sleep_entered_flag_n   = 1'b0;
          status_d.watchdog_expiry_flag_n = 1'b1;
          sleep_d = 1'b1;
        end
        SXS_OP_SUB_FILE, SXS_OP_SUB_LIT, SXS_OP_SUB_BORROW: begin
          if (instr_in.op == SXS_OP_SUB_FILE) begin
            sr = sub_op(instr_in.file_data, acc_q, 1'b0);
          end else if (instr_in.op == SXS_OP_SUB_LIT) begin
            sr = sub_op(instr_in.literal, acc_q, 1'b0);
          end else begin
            sr = sub_op(instr_in.file_data, acc_q, ~status_q.carry);
          end
          res = sr[7:0];
          status_d.zero              = (res == 8'h00);
          status_d.carry             = sr[8];
          status_d.nibble_carry_flag = sr[9];
          if (instr_in.op != SXS_OP_SUB_LIT && instr_in.dest == DEST_FILE) begin
            wr_d = '{we: 1'b1, addr: instr_in.file_addr, data: res};
          end else begin
            acc_d = res;
          end
        end
        SXS_OP_NIBBLE_EXCHANGE: begin
          res = {instr_in.file_data[3:0], instr_in.file_data[7:4]};
          if (instr_in.dest == DEST_FILE) begin
            wr_d = '{we: 1'b1, addr: instr_in.file_addr, data: res};
          end else begin
            acc_d = res;
          end
        end
        SXS_OP_LOAD_DIR: begin
          if (dir_sel[0]) begin
            dir_a_d = acc_q;
          end
          if (dir_sel[1]) begin
            dir_b_d = acc_q;
          end
          if (dir_sel[2]) begin
            dir_c_d = acc_q;
          end
        end
        SXS_OP_XOR_LIT: begin
          acc_d         = acc_q ^ instr_in.literal;
          status_d.zero = ((acc_q ^ instr_in.literal) == 8'h00);
        end
        SXS_OP_XOR_FILE: begin
          res           = acc_q ^ instr_in.file_data;
          status_d.zero = (res == 8'h00);
          if (instr_in.dest == DEST_FILE) begin
            wr_d = '{we: 1'b1, addr: instr_in.file_addr, data: res};
          end else begin
            acc_d = res;
          end
        end
        default: begin
          sleep_d = 1'b0;
        end
      endcase
      if (instr_in.op != SXS_OP_SLEEP) begin
        sleep_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_q    <= ACC_RST;
      status_q <= STATUS_RST;
      wr_q     <= '0;
      dir_a_q  <= DIR_RST;
      dir_b_q  <= DIR_RST;
      dir_c_q  <= DIR_RST;
      sleep_q  <= 1'b0;
    end else begin
      acc_q    <= acc_d;
      status_q <= status_d;
      wr_q     <= wr_d;
      dir_a_q  <= dir_a_d;
      dir_b_q  <= dir_b_d;
      dir_c_q  <= dir_c_d;
      sleep_q  <= sleep_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign acc_out               = acc_q;
  assign status_out            = status_q;
  assign file_wr_out           = wr_q;
  assign port_a_direction_out  = dir_a_q;
  assign port_b_direction_out  = dir_b_q;
  assign port_c_direction_out  = dir_c_q;
  assign watchdog_count_out    = wdt_q;
  assign watchdog_prescale_out = pre_q;
  assign sleeping_out          = sleep_q;

endmodule

// ==== verilog/sxs_pkg.sv ====
package sxs_pkg;

  // ------------------------------------------------------------
  // widths and operand codes
  // ------------------------------------------------------------
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 7;
  localparam int          WDT_W        = 16;
  localparam int          PRE_W        = 8;
  localparam logic [2:0]  DIR_PORT_A   = 3'h5;
  localparam logic [2:0]  DIR_PORT_B   = 3'h6;
  localparam logic [2:0]  DIR_PORT_C   = 3'h7;
  localparam logic        DEST_ACC     = 1'h0;
  localparam logic        DEST_FILE    = 1'h1;

  // ------------------------------------------------------------
  // reset values and prescaler terminal count
  // ------------------------------------------------------------
  localparam logic [7:0]  ACC_RST      = 8'h00;
  localparam logic [7:0]  DIR_RST      = 8'hff;
  localparam logic [15:0] WDT_RST      = 16'h0000;
  localparam logic [7:0]  PRE_RST      = 8'h00;
  localparam logic [7:0]  PRE_TERM     = 8'hff;

  // ------------------------------------------------------------
  // operations and carriers
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    SXS_OP_NONE,
    SXS_OP_SLEEP,
    SXS_OP_SUB_FILE,
    SXS_OP_SUB_LIT,
    SXS_OP_SUB_BORROW,
    SXS_OP_NIBBLE_EXCHANGE,
    SXS_OP_LOAD_DIR,
    SXS_OP_XOR_LIT,
    SXS_OP_XOR_FILE
  } sxs_op_e;

  typedef struct packed {
    logic             valid;
    sxs_op_e          op;
    logic             dest;
    logic [6:0]       file_addr;
    logic [7:0]       file_data;
    logic [7:0]       literal;
  } sxs_instr_s;

  typedef struct packed {
    logic             carry;
    logic             nibble_carry_flag;
    logic             zero;
    logic             sleep_entered_flag_n;
    logic             watchdog_expiry_flag_n;
  } sxs_status_s;

  typedef struct packed {
    logic             we;
    logic [6:0]       addr;
    logic [7:0]       data;
  } sxs_file_wr_s;

  localparam sxs_status_s STATUS_RST = '{carry: 1'b0, nibble_carry_flag: 1'b0, zero: 1'b0,
                                         sleep_entered_flag_n: 1'b1,
                                         watchdog_expiry_flag_n: 1'b1};

endpackage

// ==== verification/sxs_exec_chk.sv ====
`timescale 1ns/100ps
module sxs_exec_chk
  import sxs_pkg::*;
#(
  parameter int WDT_WIDTH = 16
) (
  input wire logic                 core_clk_in,
  input wire logic                 arst_n_in,
  input wire logic                 instr_cycle_en_in,
  input wire sxs_pkg::sxs_instr_s  instr_in,
  input wire logic [7:0]           acc_out,
  input wire sxs_pkg::sxs_status_s status_out,
  input wire sxs_pkg::sxs_file_wr_s file_wr_out,
  input wire logic [7:0]           port_a_direction_out,
  input wire logic [WDT_WIDTH-1:0] watchdog_count_out,
  input wire logic [7:0]           watchdog_prescale_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  wire logic       go = instr_cycle_en_in & instr_in.valid;
  wire sxs_op_e    op = instr_in.op;
  wire logic [7:0] fd = instr_in.file_data;
  wire logic [7:0] df = fd - acc_out;
  wire logic [7:0] dl = instr_in.literal - acc_out;
  wire logic [7:0] db = df - {7'h00, ~status_out.carry};
  wire logic [7:0] sw = {fd[3:0], fd[7:4]};
  wire logic [7:0] xl = instr_in.literal ^ acc_out;
  wire logic       nb = fd >= acc_out;
  a_sleep_wdt_zero: assert property (go && op == SXS_OP_SLEEP |=>
    watchdog_count_out == '0 && watchdog_prescale_out == 8'h00) else $error("wdt not cleared");
  a_sleep_flag_set: assert property (go && op == SXS_OP_SLEEP |=>
    !status_out.sleep_entered_flag_n && status_out.watchdog_expiry_flag_n) else $error("flags");
  a_sub_file_acc: assert property (go && op == SXS_OP_SUB_FILE &&
    !instr_in.dest |=> acc_out == $past(df) && status_out.carry == $past(nb) &&
    status_out.zero == (acc_out == 8'h00)) else $error("sub file result");
  a_sub_lit_acc: assert property (go && op == SXS_OP_SUB_LIT |=> acc_out == $past(dl))
    else $error("sub literal result");
  a_borrow_file: assert property (go && op == SXS_OP_SUB_BORROW && instr_in.dest |=>
    file_wr_out.we && file_wr_out.data == $past(db)) else $error("borrow result");
  a_swap_file: assert property (go && op == SXS_OP_NIBBLE_EXCHANGE && instr_in.dest |=>
    file_wr_out.we && file_wr_out.data == $past(sw)) else $error("swap result");
  a_dir_a_load: assert property (go && op == SXS_OP_LOAD_DIR &&
    instr_in.file_addr == 7'h05 |=> port_a_direction_out == $past(acc_out) &&
    $stable(status_out)) else $error("dir a load");
  a_xor_lit_acc: assert property (go && op == SXS_OP_XOR_LIT |=>
    acc_out == $past(xl) && $stable(status_out.carry)) else $error("xor literal result");
  a_xor_file_dest: assert property (go && op == SXS_OP_XOR_FILE && instr_in.dest |=>
    file_wr_out.we && file_wr_out.data == $past(fd ^ acc_out)) else $error("xor file result");
  c_sleep: cover property (go && op == SXS_OP_SLEEP);
  c_borrow: cover property (go && op == SXS_OP_SUB_BORROW);
  c_dir: cover property (go && op == SXS_OP_LOAD_DIR);
  c_xor_file: cover property (go && op == SXS_OP_XOR_FILE && instr_in.dest);
endmodule
bind sxs_exec sxs_exec_chk #(.WDT_WIDTH(WDT_WIDTH)) i_sxs_exec_chk (.core_clk_in(core_clk_in),
  .arst_n_in(arst_n_in), .instr_cycle_en_in(instr_cycle_en_in), .instr_in(instr_in),
  .acc_out(acc_out), .status_out(status_out), .file_wr_out(file_wr_out),
  .port_a_direction_out(port_a_direction_out), .watchdog_count_out(watchdog_count_out),
  .watchdog_prescale_out(watchdog_prescale_out));

// ==== verification/subtract_xor_swap_sleep_exec_test.sv ====
`timescale 1ns/100ps
module subtract_xor_swap_sleep_exec_test;
  import sxs_pkg::*;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         en = 1'b0;
  logic         wdt_en = 1'b0;
  sxs_instr_s   ins = '0;
  logic [7:0]   acc, pa, pb, pc, pre;
  logic [15:0]  wdc;
  sxs_status_s  st;
  sxs_file_wr_s fw;
  logic         slp;
  int           num_errors = 0;
  int           checks_done = 0;
  int           cyc = 0;
  sxs_exec #(.WDT_WIDTH(16)) i_sxs_exec (.core_clk_in(clk), .arst_n_in(rst_n),
    .instr_cycle_en_in(en), .instr_in(ins), .wdt_enable_in(wdt_en), .acc_out(acc),
    .status_out(st), .file_wr_out(fw), .port_a_direction_out(pa), .port_b_direction_out(pb),
    .port_c_direction_out(pc), .watchdog_count_out(wdc), .watchdog_prescale_out(pre),
    .sleeping_out(slp));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one enabled op; file_addr carries k too, returns after the result lands
  task automatic run(input sxs_op_e op, input logic d, input logic [7:0] f, input logic [7:0] k);
    // one idle edge first, so en never falls and rises in one time step
    @(posedge clk);
    #1;
    ins = '{valid: 1'b1, op: op, dest: d, file_addr: k[6:0], file_data: f, literal: k};
    en = 1'b1;
    @(posedge clk);
    #1;
    en = 1'b0;
  endtask
  task automatic set_acc(input logic [7:0] v);
    run(SXS_OP_XOR_LIT, DEST_FILE, 8'h00, acc ^ v);
    chk({fw.we, acc, st.zero}, {1'b0, v, v == 8'h00});
  endtask
  task automatic t_sleep();
    chk({pa, pb}, 16'hffff);
    chk({pc, st}, {8'hff, STATUS_RST});
    // enable high, valid low: no op runs, the prescaler counts 300 ticks and the watchdog count reaches 1
    wdt_en = 1'b1;
    ins = '{valid: 1'b0, op: SXS_OP_XOR_LIT, dest: DEST_ACC, file_addr: 7'h00,
           file_data: 8'h00, literal: 8'h5a};
    en = 1'b1;
    repeat (300) @(posedge clk);
    #1;
    chk({acc, wdc, pre}, {8'h00, 16'h0001, 8'h2c});
    run(SXS_OP_SLEEP, DEST_ACC, 8'h00, 8'h00);
    chk({wdc, pre}, 24'h0);
    chk({st.sleep_entered_flag_n, st.watchdog_expiry_flag_n, slp}, 3'b011);
    wdt_en = 1'b0;
    run(SXS_OP_NONE, DEST_ACC, 8'h00, 8'h00);
    chk({slp, wdc, pre}, 25'h0);
  endtask
  task automatic t_sub();
    set_acc(8'h03);
    run(SXS_OP_SUB_FILE, DEST_FILE, 8'h05, 8'h11);
    chk({fw.we, fw.addr, fw.data}, 16'h9102);
    chk({acc, st.carry, st.nibble_carry_flag, st.zero}, {8'h03, 3'b110});
    @(posedge clk);
    #1;
    chk(fw.we, 1'b0);
    run(SXS_OP_SUB_FILE, DEST_ACC, 8'h02, 8'h00);
    chk({acc, st.carry, st.nibble_carry_flag, st.zero}, {8'hff, 3'b000});
    run(SXS_OP_SUB_BORROW, DEST_FILE, 8'h00, 8'h12);
    chk({fw.we, fw.data, st.carry, st.zero}, {1'b1, 8'h00, 2'b01});
    run(SXS_OP_SUB_BORROW, DEST_ACC, 8'h10, 8'h00);
    chk(acc, 8'h10);
    run(SXS_OP_SUB_LIT, DEST_FILE, 8'h00, 8'h10);
    chk({fw.we, acc, st.carry, st.zero}, {1'b0, 8'h00, 2'b11});
  endtask
  task automatic t_swap_xor();
    run(SXS_OP_NIBBLE_EXCHANGE, DEST_FILE, 8'h3c, 8'h15);
    chk({fw.we, fw.data, st.zero}, {1'b1, 8'hc3, 1'b1});
    run(SXS_OP_NIBBLE_EXCHANGE, DEST_ACC, 8'ha5, 8'h00);
    chk(acc, 8'h5a);
    run(SXS_OP_XOR_FILE, DEST_FILE, 8'h5a, 8'h16);
    chk({fw.we, fw.data, acc, st.zero}, {1'b1, 8'h00, 8'h5a, 1'b1});
    run(SXS_OP_XOR_FILE, DEST_ACC, 8'hff, 8'h00);
    chk({acc, st.zero, st.carry}, {8'ha5, 2'b01});
  endtask
  task automatic t_dir();
    for (int i = 4; i < 8; i++) begin
      set_acc(8'h40 + 8'(i));
      run(SXS_OP_LOAD_DIR, DEST_ACC, 8'h00, 8'(i));
    end
    chk({pa, pb}, 16'h4546);
    chk({pc, st.zero}, {8'h47, 1'b0});
    ins.op = SXS_OP_SUB_LIT;
    @(posedge clk);
    #1;
    chk(acc, 8'h47);
    // operand 13 shares its low bits with 5 and must load nothing
    run(SXS_OP_LOAD_DIR, DEST_ACC, 8'h00, 8'h0d);
    chk({pa, pb, pc}, 24'h454647);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_sleep();
    t_sub();
    t_swap_xor();
    t_dir();
    stop_test();
  end
endmodule
